/* File: hdl/ccd_pkg.sv */
package ccd_pkg;

	localparam int unsigned CCD_NUM_CH  = 4;
	localparam int unsigned CCD_NUM_OUT = 8;

	// Register map, byte addresses on the configuration port
	localparam logic [7:0] CCD_CH_BASE    = 8'h20;
	localparam logic [7:0] CCD_CH_STRIDE  = 8'h10;
	localparam logic [7:0] CCD_OFS_DIV    = 8'h00;
	localparam logic [7:0] CCD_OFS_PHASE  = 8'h01;
	localparam logic [7:0] CCD_OFS_CHPD   = 8'h02;
	localparam logic [7:0] CCD_OFS_OUT    = 8'h04;

	// Field positions
	localparam int unsigned CCD_DIV_MSB   = 3;
	localparam int unsigned CCD_PD_BIT    = 7;

	// Reset values
	localparam logic [3:0] CCD_DIV_RST_AD  = 4'h0;
	localparam logic [2:0] CCD_DIV_RST_BC  = 3'h1;
	localparam logic [7:0] CCD_PHASE_RST   = 8'h00;
	localparam logic       CCD_PD_RST      = 1'b0;

	// Output k belongs to channel CCD_OUT_CH[k], slot CCD_OUT_SLOT[k]
	localparam logic [7:0][1:0] CCD_OUT_CH   = {2'h3, 2'h2, 2'h2, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0};
	localparam logic [7:0][1:0] CCD_OUT_SLOT = {2'h0, 2'h1, 2'h0, 2'h1, 2'h0, 2'h2, 2'h1, 2'h0};

	function automatic logic [4:0] ccd_ratio(input logic [3:0] sel);
		logic [4:0] r;
		r = 5'h01;
		case (sel)
			4'h1: r = 5'h02;
			4'h2: r = 5'h03;
			4'h3: r = 5'h04;
			4'h4: r = 5'h06;
			4'h5: r = 5'h08;
			4'h6: r = 5'h0C;
			4'h7: r = 5'h10;
			4'h8: r = 5'h18;
			default: r = 5'h01;
		endcase
		return r;
	endfunction

	function automatic logic [7:0] ccd_ch_addr(input logic [1:0] ch, input logic [7:0] ofs);
		return 8'(CCD_CH_BASE + CCD_CH_STRIDE * {6'h00, ch} + ofs);
	endfunction

endpackage

/* File: hdl/ccd_chan.sv */
`timescale 1ns/10ps
module ccd_chan
	import ccd_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       ce_i,
	input  wire logic [3:0] div_sel_i,
	input  wire logic [7:0] phase_i,
	input  wire logic       pwrdn_i,
	input  wire logic       restart_i,
	output logic            clk_lvl_o
);

	typedef struct packed {
		logic [7:0] dly;
		logic [4:0] cnt;
		logic       run;
		logic       lvl;
	} ccd_chan_state_type;

	ccd_chan_state_type s_q;
	ccd_chan_state_type s_d;
	logic [4:0]         ratio;

	always_comb
	begin
		s_d   = s_q;
		ratio = ccd_ratio(div_sel_i);
		// Powered down: parked low, delay reloaded so power-up restarts aligned
		if (restart_i || pwrdn_i)
		begin
			s_d.run = 1'b0;
			s_d.dly = phase_i;
			s_d.cnt = 5'h00;
			s_d.lvl = 1'b0;
		end
		else if (!s_q.run)
		begin
			s_d.lvl = 1'b0;
			if (s_q.dly == 8'h00)
				s_d.run = 1'b1;
			else
				s_d.dly = s_q.dly - 8'h01;
		end
		else
		begin
			if (ratio == 5'h01)
				s_d.lvl = 1'b1;
			else
				s_d.lvl = (s_q.cnt < (ratio >> 1));
			s_d.cnt = (s_q.cnt >= ratio - 5'h01) ? 5'h00 : s_q.cnt + 5'h01;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			s_q <= '0;
		else if (ce_i)
			s_q <= s_d;
	end

	assign clk_lvl_o = s_q.lvl;

endmodule

/* File: hdl/ccd_top.sv */
`timescale 1ns/10ps
// Function
// - Divider select 0000 passes the input clock straight through with the divider idle.
// - Divider selects 0001 to 1000 divide by 2, 3, 4, 6, 8, 12, 16 and 24; other codes act as bypass.
// - Reset loads 0000 into channels A and D, and 001 plus the strap level into channels B and C.
// - A set channel power-down bit stops the whole channel; it resets to 0.
// - A set output power-down bit stops that output only; it resets to 0.
// - The channel clock starts after phase delay times one input period, 0 to 255; it resets to 0.
module ccd_top
	import ccd_pkg::*;
(
	input  wire logic                   CLK_SYS_I,
	input  wire logic                   RST_I,
	input  wire logic                   CE_I,
	input  wire logic                   BC_DIV_DEFAULT_STRAP_I,
	input  wire logic [7:0]             REG_ADDR_I,
	input  wire logic [7:0]             REG_WDATA_I,
	input  wire logic                   REG_WR_I,
	input  wire logic                   REG_RD_I,
	output logic      [7:0]             REG_RDATA_O,
	output logic      [CCD_NUM_OUT-1:0] CLOCK_OUTPUT_O
);

	typedef struct packed {
		logic [3:0][3:0] div;
		logic [3:0][7:0] phase;
		logic [3:0]      chan_pwrdn;
		logic [7:0]      out_pwrdn;
		logic [3:0]      restart;
		logic [7:0]      rdata;
		logic [7:0]      qout;
	} ccd_top_state_type;

	ccd_top_state_type s_q;
	ccd_top_state_type s_d;
	ccd_top_state_type s_rst;
	logic [3:0]        chan_lvl;

	always_comb
	begin
		s_rst            = '0;
		s_rst.div[0]     = CCD_DIV_RST_AD;
		s_rst.div[3]     = CCD_DIV_RST_AD;
		s_rst.div[1]     = {CCD_DIV_RST_BC, BC_DIV_DEFAULT_STRAP_I};
		s_rst.div[2]     = {CCD_DIV_RST_BC, BC_DIV_DEFAULT_STRAP_I};
		s_rst.phase      = {4{CCD_PHASE_RST}};
		s_rst.chan_pwrdn = {4{CCD_PD_RST}};
		s_rst.out_pwrdn  = {8{CCD_PD_RST}};
		s_rst.restart    = 4'hF;
	end

	always_comb
	begin
		s_d         = s_q;
		s_d.restart = 4'h0;
		if (REG_WR_I)
		begin
			for (int c = 0; c < CCD_NUM_CH; c++)
			begin
				if (REG_ADDR_I == ccd_ch_addr(2'(c), CCD_OFS_DIV))
				begin
					s_d.div[c]     = REG_WDATA_I[CCD_DIV_MSB:0];
					s_d.restart[c] = 1'b1;
				end
				else if (REG_ADDR_I == ccd_ch_addr(2'(c), CCD_OFS_PHASE))
				begin
					s_d.phase[c]   = REG_WDATA_I;
					s_d.restart[c] = 1'b1;
				end
				else if (REG_ADDR_I == ccd_ch_addr(2'(c), CCD_OFS_CHPD))
				begin
					s_d.chan_pwrdn[c] = REG_WDATA_I[CCD_PD_BIT];
				end
			end
			for (int k = 0; k < CCD_NUM_OUT; k++)
			begin
				if (REG_ADDR_I == ccd_ch_addr(CCD_OUT_CH[k], 8'(CCD_OFS_OUT + {6'h00, CCD_OUT_SLOT[k]})))
					s_d.out_pwrdn[k] = REG_WDATA_I[CCD_PD_BIT];
			end
		end
		// Unmapped and reserved bits read as zero
		if (REG_RD_I)
		begin
			s_d.rdata = 8'h00;
			for (int c = 0; c < CCD_NUM_CH; c++)
			begin
				if (REG_ADDR_I == ccd_ch_addr(2'(c), CCD_OFS_DIV))
					s_d.rdata = {4'h0, s_q.div[c]};
				else if (REG_ADDR_I == ccd_ch_addr(2'(c), CCD_OFS_PHASE))
					s_d.rdata = s_q.phase[c];
				else if (REG_ADDR_I == ccd_ch_addr(2'(c), CCD_OFS_CHPD))
					s_d.rdata = {s_q.chan_pwrdn[c], 7'h00};
			end
			for (int k = 0; k < CCD_NUM_OUT; k++)
			begin
				if (REG_ADDR_I == ccd_ch_addr(CCD_OUT_CH[k], 8'(CCD_OFS_OUT + {6'h00, CCD_OUT_SLOT[k]})))
					s_d.rdata = {s_q.out_pwrdn[k], 7'h00};
			end
		end
		for (int k = 0; k < CCD_NUM_OUT; k++)
			s_d.qout[k] = chan_lvl[CCD_OUT_CH[k]] & ~s_q.out_pwrdn[k];
	end

	// Synchronous reset, so the strap level may be loaded directly
	always_ff @(posedge CLK_SYS_I)
	begin
		if (RST_I)
			s_q <= s_rst;
		else if (CE_I)
			s_q <= s_d;
	end

	for (genvar c = 0; c < CCD_NUM_CH; c++)
	begin : g_chan
		ccd_chan u_chan (
			.clk_i     (CLK_SYS_I),
			.rst_i     (RST_I),
			.ce_i      (CE_I),
			.div_sel_i (s_q.div[c]),
			.phase_i   (s_q.phase[c]),
			.pwrdn_i   (s_q.chan_pwrdn[c]),
			.restart_i (s_q.restart[c]),
			.clk_lvl_o (chan_lvl[c])
		);
	end

	assign REG_RDATA_O    = s_q.rdata;
	assign CLOCK_OUTPUT_O = s_q.qout;

endmodule

/* File: tb/ccd_chk.sv */
`timescale 1ns/10ps
module ccd_chk
	import ccd_pkg::*;
(
	input	wire logic	CLK_SYS_I,
	input	wire logic	RST_I,
	input	wire logic	CE_I,
	input	wire logic	BC_DIV_DEFAULT_STRAP_I,
	input	wire logic [7:0]	REG_ADDR_I,
	input	wire logic [7:0]	REG_WDATA_I,
	input	wire logic	REG_WR_I,
	input	wire logic	REG_RD_I,
	input	wire logic [7:0]	REG_RDATA_O,
	input	wire logic [CCD_NUM_OUT-1:0]	CLOCK_OUTPUT_O
);
	default clocking @(posedge CLK_SYS_I);
	endclocking
	default disable iff (RST_I);
	sequence wr(a);
		CE_I && REG_WR_I && !REG_RD_I && REG_ADDR_I == a;
	endsequence
	property rw(a, m);
		wr(a) ##1 CE_I && REG_RD_I && !REG_WR_I && REG_ADDR_I == a |=> REG_RDATA_O == ($past(REG_WDATA_I, 2) & m);
	endproperty
	AST_DIV_RW: assert property (rw(8'h30, 8'h0F)) else $error("div rw");
	AST_PH_RW: assert property (rw(8'h41, 8'hFF)) else $error("phase rw");
	AST_PD_RW: assert property (rw(8'h52, 8'h80)) else $error("pd rw");
	AST_RST_BC: assert property ($fell(RST_I) && CE_I && REG_RD_I && !REG_WR_I && REG_ADDR_I == 8'h30
		|=> REG_RDATA_O == {7'h01, $past(BC_DIV_DEFAULT_STRAP_I, 2)}) else $error("bc reset");
	// Only valid straight after reset, before any write touches A or D
	AST_BYPASS: assert property ($fell(RST_I) ##0 (CE_I && !REG_WR_I)[*8]
		|-> CLOCK_OUTPUT_O[0] && CLOCK_OUTPUT_O[7]) else $error("bypass");
	AST_OUT_PD: assert property (wr(8'h24) ##0 REG_WDATA_I[7] ##1 CE_I[*2]
		|-> !CLOCK_OUTPUT_O[0]) else $error("out pd");
	AST_CH_PD: assert property (wr(8'h22) ##0 REG_WDATA_I[7] ##1 CE_I[*4]
		|-> CLOCK_OUTPUT_O[2:0] == 3'h0) else $error("ch pd");
	cover property ($fell(RST_I));
	cover property (wr(8'h22) ##0 REG_WDATA_I[7]);
	cover property (wr(8'h20));
endmodule
bind ccd_top ccd_chk u_chk (.CLK_SYS_I, .RST_I, .CE_I, .BC_DIV_DEFAULT_STRAP_I, .REG_ADDR_I, .REG_WDATA_I,
	.REG_WR_I, .REG_RD_I, .REG_RDATA_O, .CLOCK_OUTPUT_O);

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb_top;
	import ccd_pkg::*;
	logic	clk = 0, rst = 1, ce = 1, strap = 1, wr = 0, rd = 0;
	logic [7:0]	addr = 0, wd = 0, rdata, q, snap;
	int	num_errors = 0, total_checks = 0, n, m;
	int	rat[9] = '{1, 2, 3, 4, 6, 8, 12, 16, 24};
	logic [23:0]	rows[5] = '{24'h30F505, 24'h41A5A5, 24'h52FF80, 24'h357F00, 24'h23FF00};
	always #2 clk = ~clk;
	ccd_top dut (.CLK_SYS_I(clk), .RST_I(rst), .CE_I(ce), .BC_DIV_DEFAULT_STRAP_I(strap), .REG_ADDR_I(addr),
		.REG_WDATA_I(wd), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .CLOCK_OUTPUT_O(q));
	// Hold keeps the strobe up so the next access follows back to back
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic hold = 1'b0);
		wr = w;
		rd = !w;
		addr = a;
		wd = d;
		@(negedge clk);
		if (!hold)
		begin
			wr = 0;
			rd = 0;
			@(negedge clk);
		end
	endtask
	task automatic count_hi(input int b, output int c);
		c = 0;
		repeat (48)
		begin
			@(negedge clk);
			if (q[b] === 1'b1)
				c++;
		end
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Ratio sweep dominates: about 1300 cycles in all
	initial
	begin
		#10000;
		num_errors++;
		close_out();
	end
	initial
	begin
		repeat (5) @(negedge clk);
		rst = 0;
		acc(0, 8'h30, 0);
		`CHK("bc div", 8'h03, rdata)
		`CHK("out", 8'h00, q)
		repeat (8) @(negedge clk);
		`CHK("bypass", 2'h3, {q[7], q[0]})
		count_hi(3, n);
		`CHK("b div4", 24, n)
		$display("reset done");
		foreach (rows[i])
		begin
			acc(1, rows[i][23:16], rows[i][15:8], 1'b1);
			acc(0, rows[i][23:16], 0);
			`CHK("reg", rows[i][7:0], rdata)
		end
		$display("regs done");
		// Count of highs over 48 cycles is phase independent
		for (int k = 1; k < 10; k++)
		begin
			m = rat[k % 9];
			acc(1, 8'h20, 8'(k % 9));
			repeat (60) @(negedge clk);
			count_hi(0, n);
			`CHK("ratio", (m == 1) ? 48 : 48 / m * (m / 2), n)
		end
		$display("ratios done");
		acc(1, 8'h22, 8'h80);
		repeat (6) @(negedge clk);
		`CHK("ch pd", 3'h0, q[2:0])
		acc(1, 8'h22, 8'h00);
		acc(1, 8'h25, 8'h80);
		repeat (9) @(negedge clk);
		`CHK("out pd", 3'h5, q[2:0])
		acc(1, 8'h24, 8'h80);
		`CHK("a0 pd", 1'b0, q[0])
		acc(1, 8'h24, 8'h00);
		acc(1, 8'h25, 8'h00);
		$display("pd done");
		// Phase 32 at /1: low until 4 + 32 cycles after the write edge
		acc(1, 8'h21, 8'h20);
		repeat (34) @(negedge clk);
		`CHK("phase lo", 1'b0, q[0])
		@(negedge clk);
		`CHK("phase hi", 1'b1, q[0])
		$display("phase done");
		// Odd cycle count at /2, so a missed freeze shows
		acc(1, 8'h20, 8'h01);
		repeat (45) @(negedge clk);
		ce = 0;
		snap = q;
		acc(1, 8'h20, 8'h00);
		repeat (3) @(negedge clk);
		`CHK("freeze", snap, q)
		ce = 1;
		acc(0, 8'h20, 0);
		`CHK("freeze wr", 8'h01, rdata)
		$display("freeze done");
		rst = 1;
		strap = 0;
		repeat (5) @(negedge clk);
		rst = 0;
		acc(0, 8'h30, 0);
		`CHK("bc div strap0", 8'h02, rdata)
		repeat (8) @(negedge clk);
		`CHK("bypass rerst", 2'h3, {q[7], q[0]})
		count_hi(3, n);
		`CHK("b div3", 16, n)
		count_hi(5, n);
		`CHK("c div3", 16, n)
		$display("rerst done");
		close_out();
	end
endmodule
